// ---- slpc_top.sv ----
// serial link protocol controller: packet send, retries, modem control
module slpc_top
  import slpc_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC,
  parameter int MS_DIV   = MS_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        bkup_ok,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  input  wire logic        pkt_start,
  input  wire logic        pkt_valid,
  input  wire logic [7:0]  pkt_data,
  input  wire logic        pkt_last,
  output logic             pkt_ready,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic      [7:0]  tx_data,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  input  wire logic        rx_ctl,
  input  wire logic        rx_good,
  input  wire logic        rx_embedded,
  input  wire logic [7:0]  rx_seq,
  output logic             rx_pass,
  input  wire logic        msg_sent,
  input  wire logic        msg_reply,
  input  wire logic        dcd,
  input  wire logic        cts,
  output logic             rts
);
  logic [1:0]  rs_reg;
  logic        rst_n;
  logic        tick;
  logic        ms_tick;
  logic [4:0]  ctrl_reg;
  logic [15:0] ack_tmo_reg;
  logic [7:0]  enq_max_reg;
  logic [7:0]  nak_max_reg;
  logic [13:0] msg_tmo_reg;
  logic [4:0]  init_dly_reg;
  logic [4:0]  sv_ctrl_reg;
  logic [15:0] sv_ack_reg;
  logic [7:0]  sv_enq_reg;
  logic [7:0]  sv_nak_reg;
  logic [13:0] sv_msg_reg;
  logic [4:0]  sv_dly_reg;
  logic        sv_valid_reg;
  logic        loaded_reg;
  logic [IRQ_W-1:0] ist_reg;
  logic [IRQ_W-1:0] imask_reg;
  logic [IRQ_W-1:0] iev;
  slpc_tx_e    tx_reg;
  logic [15:0] ack_cnt_reg;
  logic [7:0]  enq_cnt_reg;
  logic [7:0]  nak_cnt_reg;
  logic [7:0]  last_seq_reg;
  logic        have_seq_reg;
  logic        host_emb_reg;
  logic        carrier_reg;
  logic [7:0]  init_chr_reg;
  logic        init_pend_reg;
  logic        init_done_reg;
  logic [15:0] init_ms_reg;
  logic [13:0] msg_cnt_reg;
  logic        msg_busy_reg;
  logic        resp_pend_reg;
  logic [7:0]  resp_chr_reg;
  logic        ck_clr;
  logic        ck_en;
  logic [15:0] ck_code;
  logic        hs_on;
  logic        link_ok;
  logic        can_send;
  logic        ack_rx;
  logic        nak_rx;
  logic        is_dup;
  logic        emb_on;
  logic        resp_go;
  logic        init_go;
  logic        hold_v_reg;
  logic [7:0]  hold_reg;
  logic [7:0]  sv_chr_reg;

  initial begin
    if (TICK_DIV < 2 || MS_DIV < 2) $error("tick divider too small");
  end

  // reset release through two flops
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rs_reg <= 2'b00;
    end else begin
      rs_reg <= {rs_reg[0], 1'b1};
    end
  end
  assign rst_n = rs_reg[1];

  slpc_tick #(.DIV(TICK_DIV)) u_tick5 (.clk(clk), .rst_n(rst_n), .tick(tick));
  slpc_tick #(.DIV(MS_DIV))   u_tick1 (.clk(clk), .rst_n(rst_n), .tick(ms_tick));

  assign hs_on    = ctrl_reg[C_HWHS] | ctrl_reg[C_CCD];
  assign link_ok  = !ctrl_reg[C_CCD] || carrier_reg;
  assign can_send = link_ok && tx_ready && (!hs_on || cts);
  assign ack_rx   = rx_valid && rx_ctl && rx_data == CH_ACK;
  assign nak_rx   = rx_valid && rx_ctl && rx_data == CH_NAK;
  assign is_dup   = have_seq_reg && rx_seq == last_seq_reg;
  assign emb_on   = !ctrl_reg[C_AUTOEMB] || host_emb_reg;
  // reply byte leaves now, ahead of packet data
  assign resp_go  = can_send && resp_pend_reg && (emb_on || tx_reg != TX_SEND);
  // init byte only on an idle line, cleared as it leaves
  assign init_go  = can_send && init_pend_reg && tx_reg == TX_IDLE && !resp_pend_reg && !hold_v_reg;

  // settings: defaults, then saved copy if backup intact
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg     <= CTRL_RST;
      ack_tmo_reg  <= ACK_TMO_RST;
      enq_max_reg  <= ENQ_RETRY_RST;
      nak_max_reg  <= NAK_RETRY_RST;
      msg_tmo_reg  <= MSG_TMO_RST;
      init_dly_reg <= INIT_DLY_RST;
      init_chr_reg <= 8'h00;
      loaded_reg   <= 1'b0;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      if (sv_valid_reg && bkup_ok) begin
        ctrl_reg     <= sv_ctrl_reg;
        ack_tmo_reg  <= sv_ack_reg;
        enq_max_reg  <= sv_enq_reg;
        nak_max_reg  <= sv_nak_reg;
        msg_tmo_reg  <= sv_msg_reg;
        init_dly_reg <= sv_dly_reg;
        init_chr_reg <= sv_chr_reg;
      end
    end else if (reg_wr) begin
      case (reg_addr)
        A_CTRL:     ctrl_reg <= reg_wdata[4:0];
        A_ACK_TMO:  ack_tmo_reg <= reg_wdata[15:0];
        A_RETRY: begin
          enq_max_reg <= reg_wdata[7:0];
          nak_max_reg <= reg_wdata[15:8];
        end
        A_MSG_TMO:  msg_tmo_reg <= 14'(reg_wdata[13:0] - (reg_wdata[13:0] % 14'(MSG_STEP_MS)));
        A_INIT_DLY: init_dly_reg <= reg_wdata[4:0];
        A_INIT_CHR: init_chr_reg <= reg_wdata[7:0];
        default: ;
      endcase
    end
  end

  // saved copy, held only on backup power; no reset branch on purpose
  always_ff @(posedge clk) begin
    if (!bkup_ok) begin
      sv_valid_reg <= 1'b0;
    end else if (rst_n && reg_wr && reg_addr == A_SAVE) begin
      sv_valid_reg <= 1'b1;
      sv_ctrl_reg  <= ctrl_reg;
      sv_ack_reg   <= ack_tmo_reg;
      sv_enq_reg   <= enq_max_reg;
      sv_nak_reg   <= nak_max_reg;
      sv_msg_reg   <= msg_tmo_reg;
      sv_dly_reg   <= init_dly_reg;
      sv_chr_reg   <= init_chr_reg;
    end
  end

  // carrier detect, registered each cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_reg <= 1'b0;
    end else begin
      carrier_reg <= dcd;
    end
  end

  // init string delay then one request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_ms_reg   <= 16'h0000;
      init_pend_reg <= 1'b0;
      init_done_reg <= 1'b0;
    end else if (loaded_reg && !init_done_reg && !init_pend_reg) begin
      if (init_ms_reg >= 16'(init_dly_reg) * 16'd1000) begin
        init_pend_reg <= init_chr_reg != 8'h00;
        init_done_reg <= init_chr_reg == 8'h00;
      end else if (ms_tick) begin
        init_ms_reg <= init_ms_reg + 16'h0001;
      end
    end else if (init_go) begin
      init_pend_reg <= 1'b0;
      init_done_reg <= 1'b1;
    end
  end

  // duplicate tracking and host embedding detection
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      last_seq_reg <= 8'h00;
      have_seq_reg <= 1'b0;
      host_emb_reg <= 1'b0;
      resp_pend_reg <= 1'b0;
      resp_chr_reg <= 8'h00;
      rx_pass      <= 1'b0;
    end else begin
      rx_pass <= 1'b0;
      if (rx_valid && rx_embedded) begin
        host_emb_reg <= 1'b1;
      end
      if (rx_valid && !rx_ctl) begin
        resp_pend_reg <= 1'b1;
        resp_chr_reg  <= rx_good ? CH_ACK : CH_NAK;
        if (rx_good) begin
          last_seq_reg <= rx_seq;
          have_seq_reg <= 1'b1;
          rx_pass <= !(ctrl_reg[C_DUP] && is_dup);
        end
      end else if (resp_go) begin
        resp_pend_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_cnt_reg  <= 14'h0000;
      msg_busy_reg <= 1'b0;
    end else if (msg_sent) begin
      msg_cnt_reg  <= 14'h0000;
      msg_busy_reg <= 1'b1;
    end else if (msg_busy_reg && msg_reply) begin
      msg_busy_reg <= 1'b0;
    end else if (msg_busy_reg && ms_tick) begin
      msg_cnt_reg <= msg_cnt_reg + 14'h0001;
      if (msg_cnt_reg + 14'h0001 >= msg_tmo_reg) begin
        msg_busy_reg <= 1'b0;
      end
    end
  end

  // transmit machine with ack wait, enq and nak retries
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg      <= TX_IDLE;
      ack_cnt_reg <= 16'h0000;
      enq_cnt_reg <= 8'h00;
      nak_cnt_reg <= 8'h00;
    end else begin
      case (tx_reg)
        TX_IDLE: begin
          if (pkt_start && link_ok && !init_pend_reg) begin
            tx_reg      <= TX_SEND;
            enq_cnt_reg <= 8'h00;
            nak_cnt_reg <= 8'h00;
          end
        end
        TX_SEND: begin
          if (pkt_valid && pkt_last && pkt_ready) begin
            tx_reg      <= TX_WAIT;
            ack_cnt_reg <= 16'h0000;
          end
        end
        TX_WAIT: begin
          if (ack_rx) begin
            tx_reg <= TX_IDLE;
          end else if (nak_rx) begin
            if (nak_cnt_reg < nak_max_reg) begin
              nak_cnt_reg <= nak_cnt_reg + 8'h01;
              tx_reg      <= TX_SEND;
            end else begin
              tx_reg <= TX_IDLE;
            end
          end else if (tick) begin
            if (ack_cnt_reg + 16'h0001 >= ack_tmo_reg) begin
              if (enq_cnt_reg < enq_max_reg) begin
                enq_cnt_reg <= enq_cnt_reg + 8'h01;
                tx_reg      <= TX_ENQ;
              end else begin
                tx_reg <= TX_IDLE;
              end
              ack_cnt_reg <= 16'h0000;
            end else begin
              ack_cnt_reg <= ack_cnt_reg + 16'h0001;
            end
          end
        end
        TX_ENQ: begin
          if (can_send && !resp_go) begin
            tx_reg <= TX_WAIT;
          end
        end
        default: tx_reg <= TX_IDLE;
      endcase
    end
  end

  // packet byte parked when the line drops or a reply goes first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_v_reg <= 1'b0;
      hold_reg   <= 8'h00;
    end else if (ck_en && (!can_send || resp_go)) begin
      hold_v_reg <= 1'b1;
      hold_reg   <= pkt_data;
    end else if (hold_v_reg && can_send && !resp_go && tx_reg != TX_ENQ) begin
      hold_v_reg <= 1'b0;
    end
  end

  // check code runs over packet bytes
  assign ck_clr = tx_reg == TX_IDLE;
  assign ck_en  = tx_reg == TX_SEND && pkt_valid && pkt_ready;
  slpc_check u_check (
    .clk     (clk),
    .rst_n   (rst_n),
    .clr     (ck_clr),
    .use_crc (ctrl_reg[C_CRC]),
    .en      (ck_en),
    .data    (pkt_data),
    .code    (ck_code)
  );

  // output byte stream and handshake lines
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid  <= 1'b0;
      tx_data   <= 8'h00;
      pkt_ready <= 1'b0;
      rts       <= 1'b0;
    end else begin
      // rts asserted while handshaking and link busy
      rts       <= hs_on && link_ok && (tx_reg != TX_IDLE || init_pend_reg || resp_pend_reg);
      pkt_ready <= tx_reg == TX_SEND && can_send && !(resp_pend_reg && emb_on) && !hold_v_reg;
      tx_valid  <= 1'b0;
      if (!can_send) begin
        tx_valid <= 1'b0;
      end else if (resp_go) begin
        // response may sit inside a packet
        tx_valid <= 1'b1;
        tx_data  <= resp_chr_reg;
      end else if (tx_reg == TX_ENQ) begin
        tx_valid <= 1'b1;
        tx_data  <= CH_ENQ;
      end else if (hold_v_reg) begin
        tx_valid <= 1'b1;
        tx_data  <= hold_reg;
      end else if (ck_en) begin
        tx_valid <= 1'b1;
        tx_data  <= pkt_data;
      end else if (init_go) begin
        tx_valid <= 1'b1;
        tx_data  <= init_chr_reg;
      end
    end
  end

  // interrupt events, sticky status cleared by read
  assign iev[I_DONE]   = tx_reg == TX_WAIT && ack_rx;
  assign iev[I_FAIL]   = tx_reg == TX_WAIT && ((nak_rx && nak_cnt_reg >= nak_max_reg) ||
                         (!ack_rx && !nak_rx && tick && ack_cnt_reg + 16'h0001 >= ack_tmo_reg
                          && enq_cnt_reg >= enq_max_reg));
  assign iev[I_RX]     = rx_valid && !rx_ctl && rx_good;
  assign iev[I_DUP]    = iev[I_RX] && ctrl_reg[C_DUP] && is_dup;
  assign iev[I_MSGTMO] = msg_busy_reg && !msg_sent && !msg_reply && ms_tick && msg_cnt_reg + 14'h0001 >= msg_tmo_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ist_reg   <= '0;
      imask_reg <= '0;
      irq       <= 1'b0;
    end else begin
      ist_reg <= ((reg_rd && reg_addr == A_IRQ_STAT) ? '0 : ist_reg) | iev;
      if (reg_wr && reg_addr == A_IRQ_MASK) begin
        imask_reg <= reg_wdata[IRQ_W-1:0];
      end
      irq <= |(ist_reg & imask_reg);
    end
  end

  // register read port, one cycle later
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        A_CTRL:     reg_rdata <= {27'h0, ctrl_reg};
        A_ACK_TMO:  reg_rdata <= {16'h0, ack_tmo_reg};
        A_RETRY:    reg_rdata <= {16'h0, nak_max_reg, enq_max_reg};
        A_MSG_TMO:  reg_rdata <= {18'h0, msg_tmo_reg};
        A_INIT_DLY: reg_rdata <= {27'h0, init_dly_reg};
        A_STATUS:   reg_rdata <= {16'h0, enq_cnt_reg[3:0], nak_cnt_reg[3:0], host_emb_reg,
                                  carrier_reg, init_done_reg, msg_busy_reg, 1'b0, tx_reg};
        A_IRQ_STAT: reg_rdata <= {27'h0, ist_reg};
        A_IRQ_MASK: reg_rdata <= {27'h0, imask_reg};
        A_INIT_CHR: reg_rdata <= {24'h0, init_chr_reg};
        default:    reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // checks
  chk_nak_resend: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_reg == TX_WAIT && nak_rx && nak_cnt_reg < nak_max_reg) |=> tx_reg == TX_SEND)
    else $error("nak did not resend");
  chk_enq_timeout: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_reg == TX_WAIT && !ack_rx && !nak_rx && tick && ack_cnt_reg + 16'h0001 >= ack_tmo_reg
     && enq_cnt_reg < enq_max_reg) |=> tx_reg == TX_ENQ && ack_cnt_reg == 16'h0000)
    else $error("timeout did not enquire");
  chk_enq_fail: assert property (@(posedge clk) disable iff (!rst_n)
    iev[I_FAIL] |=> tx_reg == TX_IDLE && ist_reg[I_FAIL])
    else $error("failure not reported");
  chk_cts_gate: assert property (@(posedge clk) disable iff (!rst_n)
    (hs_on && !cts) |=> !tx_valid)
    else $error("sent without cts");
  chk_carrier_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (ctrl_reg[C_CCD] && !carrier_reg) |=> !tx_valid)
    else $error("sent without carrier");
  chk_dup_drop: assert property (@(posedge clk) disable iff (!rst_n)
    (rx_valid && !rx_ctl && rx_good && ctrl_reg[C_DUP] && is_dup) |=> !rx_pass && resp_pend_reg)
    else $error("duplicate passed on");
  chk_msg_step: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(msg_tmo_reg) && loaded_reg && $past(loaded_reg) |-> (msg_tmo_reg % 14'(MSG_STEP_MS)) == 14'h0)
    else $error("message timeout not truncated");
  chk_ack_done: assert property (@(posedge clk) disable iff (!rst_n)
    (tx_reg == TX_WAIT && ack_rx) |=> tx_reg == TX_IDLE && ist_reg[I_DONE])
    else $error("ack not taken");
endmodule : slpc_top

// ---- slpc_pkg.sv ----
// package of constants for the serial link protocol controller
package slpc_pkg;
  // clock and tick figures
  localparam int          CLK_MHZ          = 250;
  localparam int          TICK_MS          = 5;
  localparam int          TICK_CYC         = CLK_MHZ * 1000 * TICK_MS;
  localparam int          MS_CYC           = CLK_MHZ * 1000;
  localparam int          MSG_STEP_MS      = 50;
  // register offsets (byte addresses)
  localparam logic [7:0]  A_CTRL           = 8'h00;
  localparam logic [7:0]  A_ACK_TMO        = 8'h04;
  localparam logic [7:0]  A_RETRY          = 8'h08;
  localparam logic [7:0]  A_MSG_TMO        = 8'h0c;
  localparam logic [7:0]  A_INIT_DLY       = 8'h10;
  localparam logic [7:0]  A_STATUS         = 8'h14;
  localparam logic [7:0]  A_IRQ_STAT       = 8'h18;
  localparam logic [7:0]  A_IRQ_MASK       = 8'h1c;
  localparam logic [7:0]  A_INIT_CHR       = 8'h20;
  localparam logic [7:0]  A_SAVE           = 8'h24;
  // control field positions
  localparam int          C_DUP            = 0;
  localparam int          C_CRC            = 1;
  localparam int          C_CCD            = 2;
  localparam int          C_HWHS           = 3;
  localparam int          C_AUTOEMB        = 4;
  // reset values (defaults)
  localparam logic [4:0]  CTRL_RST         = 5'h00;
  localparam logic [15:0] ACK_TMO_RST      = 16'h00c8;
  localparam logic [7:0]  ENQ_RETRY_RST    = 8'h02;
  localparam logic [7:0]  NAK_RETRY_RST    = 8'h02;
  localparam logic [13:0] MSG_TMO_RST      = 14'h2710;
  localparam logic [4:0]  INIT_DLY_RST     = 5'h00;
  // link control characters
  localparam logic [7:0]  CH_ACK           = 8'h06;
  localparam logic [7:0]  CH_NAK           = 8'h15;
  localparam logic [7:0]  CH_ENQ           = 8'h05;
  // interrupt bit positions
  localparam int          I_DONE           = 0;
  localparam int          I_FAIL           = 1;
  localparam int          I_RX             = 2;
  localparam int          I_DUP            = 3;
  localparam int          I_MSGTMO         = 4;
  localparam int          IRQ_W            = 5;
  // transmit machine
  typedef enum logic [2:0] {TX_IDLE, TX_SEND, TX_WAIT, TX_ENQ} slpc_tx_e;
endpackage : slpc_pkg

// ---- slpc_check.sv ----
// packet check code engine, block check or crc16 selected
module slpc_check
  import slpc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic        use_crc,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  output logic      [15:0] code
);
  // crc16 over one byte, reflected polynomial a001
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  // accumulate; block check is the two's complement of the sum of the bytes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code <= 16'h0000;
    end else if (clr) begin
      code <= 16'h0000;
    end else if (en) begin
      code <= use_crc ? crc_byte(code, data) : {8'h00, 8'(code[7:0] - data)};
    end
  end
endmodule : slpc_check

// ---- slpc_tick.sv ----
// divider giving one-cycle tick enables
module slpc_tick #(
  parameter int DIV = 1250000
) (
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);
  localparam int W = $clog2(DIV);
  logic [W-1:0] cnt_reg;

  initial begin
    if (DIV < 2) $error("divider too small");
  end

  // free running count, pulse on wrap
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      tick    <= 1'b0;
    end else begin
      tick    <= (cnt_reg == W'(DIV - 1));
      cnt_reg <= (cnt_reg == W'(DIV - 1)) ? '0 : cnt_reg + 1'b1;
    end
  end
endmodule : slpc_tick

// ---- slpc_host_model.sv ----
// host serial device model facing the controller's serial side
module slpc_host_model
  import slpc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       go,
  input  wire logic [1:0] cmd,
  input  wire logic [7:0] seq,
  input  wire logic       mute,
  input  wire logic       slow,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic            rx_ctl,
  output logic            rx_good,
  output logic            rx_embedded,
  output logic      [7:0] rx_seq
);
  import slpc_pkg::*;
  logic [7:0] last_rsp;

  // quiet start; no embedded replies from this host
  initial begin
    tx_ready    = 1'h1;
    rx_valid    = 1'h0;
    rx_data     = 8'h00;
    rx_ctl      = 1'h0;
    rx_good     = 1'h0;
    rx_embedded = 1'h0;
    rx_seq      = 8'h00;
    last_rsp    = CH_ACK;
  end

  // idle lines toggle so a stale value never reads as an answer
  always @(posedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'h1;
    rx_valid <= 1'h0;
    rx_data  <= ~rx_data;
    rx_ctl   <= ~rx_ctl;
    rx_good  <= ~rx_good;
    rx_seq   <= ~rx_seq;
    if (go) begin
      rx_valid <= 1'h1;
      rx_ctl   <= (cmd != 2'h3);
      rx_data  <= (cmd == 2'h2) ? CH_NAK : CH_ACK;
      rx_good  <= 1'h1;
      rx_seq   <= seq;
      if (cmd != 2'h3) last_rsp <= (cmd == 2'h2) ? CH_NAK : CH_ACK;
    // enquiry repeats reply; each valid pulse is one byte
    end else if (!mute && tx_valid && tx_data == CH_ENQ) begin
      rx_valid <= 1'h1;
      rx_ctl   <= 1'h1;
      rx_data  <= last_rsp;
      rx_good  <= 1'h1;
    end
  end
endmodule : slpc_host_model

// ---- slpc_top_bench.sv ----
// self-checking bench for the serial link protocol controller
module slpc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import slpc_pkg::*;
  localparam int TD = 8;
  localparam int MD = 4;
  logic        clk, irq, pkt_ready, tx_ready, tx_valid, rx_valid, rx_ctl, rx_good, rx_embedded, rx_pass, rts, rd_d;
  logic        rstn = 1'h0, bkup_ok = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, pkt_start = 1'h0, pkt_valid = 1'h0;
  logic        pkt_last = 1'h0, msg_sent = 1'h0, msg_reply = 1'h0, dcd = 1'h0, cts = 1'h0, go = 1'h0;
  logic        mute = 1'h0, slow = 1'h0;
  logic [1:0]  cmd = 2'h0;
  logic [7:0]  reg_addr = 8'h00, pkt_data = 8'h00, seq = 8'h00, tx_data, rx_data, rx_seq;
  logic [31:0] reg_wdata = '0, reg_rdata, rng = 32'h9311;
  logic [31:0] rq[$];
  logic [7:0]  tq[$];
  logic [39:0] dflt[6] = '{{A_CTRL, 32'h0}, {A_ACK_TMO, 32'hc8}, {A_RETRY, 32'h202}, {A_MSG_TMO, 32'h2710},
                          {A_INIT_DLY, 32'h0}, {8'h40, 32'h0}};
  int          failures = 0, cmp_count = 0, tx_seen = 0, pass_cnt = 0, n;

  slpc_top #(.TICK_DIV(TD), .MS_DIV(MD)) slpc_top_inst (.clk, .rstn, .bkup_ok, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .irq, .pkt_start, .pkt_valid, .pkt_data, .pkt_last, .pkt_ready, .tx_ready, .tx_valid,
    .tx_data, .rx_valid, .rx_data, .rx_ctl, .rx_good, .rx_embedded, .rx_seq, .rx_pass, .msg_sent, .msg_reply,
    .dcd, .cts, .rts);
  slpc_host_model slpc_host_model_inst (.clk, .tx_valid, .tx_data, .go, .cmd, .seq, .mute, .slow, .tx_ready,
    .rx_valid, .rx_data, .rx_ctl, .rx_good, .rx_embedded, .rx_seq);

  // clock of 4 ns
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  // results compared against the oldest note as they appear
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d === 1'h1) chk("reg_rdata", reg_rdata, rq.pop_front());
    if (tx_valid === 1'h1) begin // one byte per pulse
      tx_seen++;
      chk("tx_data", {24'h0, tx_data}, tq.size() ? {24'h0, tq.pop_front()} : 32'h100);
    end
    if (rx_pass === 1'h1) pass_cnt++;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    rq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'h0;
  endtask : rd

  task automatic host(input logic [1:0] c, input logic [7:0] s);
    @(posedge clk);
    go  <= 1'h1;
    cmd <= c;
    seq <= s;
    @(posedge clk);
    go <= 1'h0;
  endtask : host

  task automatic drain(input int lim);
    for (int i = 0; i < lim && tq.size() > 0; i++) @(posedge clk);
    chk("tx_pending", tq.size(), 0);
  endtask : drain

  task automatic send(input int cnt, input logic st = 1'h1);
    if (st) begin
      @(posedge clk);
      pkt_start <= 1'h1;
      @(posedge clk);
      pkt_start <= 1'h0;
    end
    for (int i = 0; i < cnt; i++) begin
      pkt_valid <= 1'h1;
      pkt_data  <= 8'h30 + 8'(i);
      pkt_last  <= (i == cnt - 1);
      tq.push_back(8'h30 + 8'(i));
      do @(posedge clk); while (pkt_ready !== 1'h1);
    end
    pkt_valid <= 1'h0;
    pkt_last  <= 1'h0;
  endtask : send

  task automatic do_reset(input logic bk);
    @(posedge clk);
    rstn    <= 1'h0;
    bkup_ok <= bk;
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    bkup_ok <= 1'h1;
  endtask : do_reset

  task automatic rx_pkt(input int cnt);
    repeat (cnt) begin
      tq.push_back(CH_ACK);
      host(2'h3, 8'h07);
      drain(50);
    end
  endtask : rx_pkt

  // watchdog well beyond the planned run
  initial begin
    repeat (40000) @(posedge clk);
    failures++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    end_of_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'h1;
    repeat (4) @(posedge clk);
    foreach (dflt[i]) rd(dflt[i][39:32], dflt[i][31:0]);
    rng = xs(rng);
    wr(A_ACK_TMO, {16'h0, rng[15:0]});
    wr(A_CTRL, 32'h1 << C_CRC);
    wr(A_INIT_CHR, 32'h41);
    wr(A_SAVE, 32'h1);
    tq.push_back(8'h41);
    do_reset(1'h1);
    drain(200);
    rd(A_ACK_TMO, {16'h0, rng[15:0]});
    rd(A_CTRL, 32'h1 << C_CRC);
    do_reset(1'h0);
    foreach (dflt[i]) rd(dflt[i][39:32], dflt[i][31:0]);
    wr(A_MSG_TMO, 32'hc7);
    rd(A_MSG_TMO, 32'h96);
    msg_sent <= 1'h1;
    @(posedge clk);
    msg_sent <= 1'h0;
    repeat (140 * MD) @(posedge clk);
    rd(A_IRQ_STAT, 32'h0);
    repeat (20 * MD) @(posedge clk);
    rd(A_IRQ_STAT, 32'h1 << I_MSGTMO);
    msg_sent <= 1'h1;
    @(posedge clk);
    msg_sent <= 1'h0;
    repeat (100) @(posedge clk);
    msg_reply <= 1'h1;
    @(posedge clk);
    msg_reply <= 1'h0;
    repeat (200 * MD) @(posedge clk);
    rd(A_IRQ_STAT, 32'h0);
    // silent host, cts low without handshaking
    mute <= 1'h1;
    send(2);
    drain(100);
    n = tx_seen;
    repeat (195 * TD) @(posedge clk);
    chk("early_enq", tx_seen, n);
    tq.push_back(CH_ENQ);
    drain(10 * TD);
    tq.push_back(CH_ENQ);
    drain(210 * TD);
    repeat (210 * TD) @(posedge clk);
    rd(A_IRQ_STAT, 32'h1 << I_FAIL);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    // nak resends with a slow transmitter
    mute <= 1'h0;
    slow <= 1'h1;
    send(2);
    drain(100);
    repeat (2) begin
      host(2'h2, 8'h00);
      send(2, 1'h0);
      drain(100);
    end
    host(2'h2, 8'h00);
    repeat (20) @(posedge clk);
    rd(A_IRQ_STAT, 32'h1 << I_FAIL);
    slow <= 1'h0;
    // interrupt raised, then cleared by the status read
    wr(A_IRQ_MASK, 32'h1 << I_DONE);
    send(2);
    drain(100);
    host(2'h1, 8'h00);
    repeat (10) @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(A_IRQ_STAT, 32'h1 << I_DONE);
    repeat (2) @(posedge clk);
    chk("irq_clear", {31'h0, irq}, 32'h0);
    // duplicate acked and dropped only when enabled
    wr(A_CTRL, 32'h1 << C_DUP);
    n = pass_cnt;
    rx_pkt(2);
    chk("rx_pass_dup", pass_cnt - n, 1);
    rd(A_IRQ_STAT, (32'h1 << I_RX) | (32'h1 << I_DUP));
    wr(A_CTRL, 32'h0);
    n = pass_cnt;
    rx_pkt(2);
    chk("rx_pass_nodup", pass_cnt - n, 2);
    // carrier holds link, forced handshaking gates on cts
    wr(A_CTRL, 32'h1 << C_CCD);
    n = tx_seen;
    pkt_start <= 1'h1;
    @(posedge clk);
    pkt_start <= 1'h0;
    repeat (40) @(posedge clk);
    chk("no_carrier", tx_seen, n);
    dcd <= 1'h1;
    fork
      send(2);
    join_none
    repeat (60) @(posedge clk);
    chk("cts_gate", tx_seen, n);
    chk("rts", {31'h0, rts}, 32'h1);
    cts <= 1'h1;
    wait fork;
    drain(100);
    host(2'h1, 8'h00);
    repeat (20) @(posedge clk);
    end_of_test();
  end
endmodule : slpc_top_bench
